// ==== rtl/pmoc_pkg.sv ====
// Shared constants and types for the program memory operation control block
package pmoc_pkg;

	// ==========================================================
	// Register bus
	localparam int               ADDR_W        = 4;
	localparam int               DATA_W        = 16;
	localparam logic [ADDR_W-1:0] ADDR_CTRL    = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_ST  = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MSK = 4'h8;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} pmoc_bus_req_t;

	// ==========================================================
	// Control register layout
	typedef struct packed {
		logic       start;
		logic       opWritePermit;
		logic       sequenceErrorFlag;
		logic [5:0] rsvHi;
		logic       eraseSel;
		logic [1:0] rsvLo;
		logic [3:0] opCode;
	} pmoc_ctrl_t;

	localparam pmoc_ctrl_t CTRL_RESET = '{start: 1'h0, opWritePermit: 1'h0, sequenceErrorFlag: 1'h0,
		rsvHi: 6'h0, eraseSel: 1'h0, rsvLo: 2'h0, opCode: 4'h0};

	// ==========================================================
	// Operation codes
	localparam logic [3:0] OPC_NOP_A      = 4'hF;
	localparam logic [3:0] OPC_ERASE_GEN  = 4'hD;
	localparam logic [3:0] OPC_WORD_OR_NOP = 4'h3;
	localparam logic [3:0] OPC_PAGE_ERASE = 4'h2;

	typedef enum logic [2:0] {
		MOP_NONE       = 3'h0,
		MOP_ERASE_GEN  = 3'h1,
		MOP_ERASE_PAGE = 3'h2,
		MOP_PROG_WORD  = 3'h3,
		MOP_NOP        = 3'h4,
		MOP_BAD        = 3'h5
	} pmoc_mem_op_t;

	// ==========================================================
	// Sequencer and interrupt status
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} pmoc_state_t;

	localparam int         IRQ_W       = 2;
	localparam int         IRQ_DONE    = 0;
	localparam int         IRQ_ERR     = 1;
	localparam logic [1:0] IRQ_RESET   = 2'h0;

endpackage

// ==== rtl/pmoc_program_memory_op_control.sv ====
// Control, sequencing and status of program memory program and erase operations
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/100ps
// What this block does
// - Write permit set allows operations to start
// - Write permit clear inhibits every operation
// - Improper sequence or abnormal end sets error
// - Start attempt under improper conditions sets error
// - Normal finish leaves error flag at zero
// - Bits 12-7 and 5-4 read zero
// - Erase select picks erase else program
// - Erase with 1101 erases general segment
// - Erase with 0010 erases one page
// - Erase with 1111 or 0011 is no-op
// - Codes 0001 and 0000 are reserved
// - Program with 0011 programs one word
// - Program with 1111, 1101, 0010 no-op
// - Unlisted codes perform no memory operation
// - Control bits other than start reset only by power-on; local reset also clears start
// - Start launches operation, hardware clears on finish
// - Start reads zero when nothing runs
module pmoc_program_memory_op_control (
	// Clock and resets
	input  wire logic                   clk,
	input  wire logic                   rstn,
	input  wire logic                   porRstn,
	// Register port
	input  wire pmoc_pkg::pmoc_bus_req_t busReq,
	output logic [pmoc_pkg::DATA_W-1:0]  rdata,
	// Memory array timing engine
	output logic                        memGo,
	output pmoc_pkg::pmoc_mem_op_t       memOp,
	input  wire logic                   memDone,
	input  wire logic                   memAbort,
	// Interrupt
	output logic                        irq
);

	// ==========================================================
	// Operation decode
	function automatic pmoc_pkg::pmoc_mem_op_t decodeOp(input logic erase, input logic [3:0] code);
		pmoc_pkg::pmoc_mem_op_t r;
		r = pmoc_pkg::MOP_BAD;
		if (erase) begin
			case (code)
				pmoc_pkg::OPC_ERASE_GEN:   r = pmoc_pkg::MOP_ERASE_GEN;
				pmoc_pkg::OPC_PAGE_ERASE:  r = pmoc_pkg::MOP_ERASE_PAGE;
				pmoc_pkg::OPC_NOP_A,
				pmoc_pkg::OPC_WORD_OR_NOP: r = pmoc_pkg::MOP_NOP;
				default:                   r = pmoc_pkg::MOP_BAD;
			endcase
		end else begin
			case (code)
				pmoc_pkg::OPC_WORD_OR_NOP: r = pmoc_pkg::MOP_PROG_WORD;
				pmoc_pkg::OPC_NOP_A,
				pmoc_pkg::OPC_ERASE_GEN,
				pmoc_pkg::OPC_PAGE_ERASE:  r = pmoc_pkg::MOP_NOP;
				default:                   r = pmoc_pkg::MOP_BAD;
			endcase
		end
		return r;
	endfunction

	// ==========================================================
	// Request decode
	pmoc_pkg::pmoc_ctrl_t   ctl;
	logic                   startBit;
	logic                   permitBit;
	logic                   errBit;
	logic                   eraseBit;
	logic [3:0]             opBits;
	pmoc_pkg::pmoc_state_t  state;
	pmoc_pkg::pmoc_ctrl_t   wv;
	pmoc_pkg::pmoc_mem_op_t reqKind;
	logic [pmoc_pkg::IRQ_W-1:0] irqStat;
	logic [pmoc_pkg::IRQ_W-1:0] irqMask;
	logic [pmoc_pkg::IRQ_W-1:0] next_irqStat;
	logic ctlWr;
	logic busy;
	logic startReq;
	logic badSeq;
	logic launch;
	logic nopDone;
	logic abortNow;
	logic doneNow;
	logic anyRst;

	assign anyRst   = !rstn || !porRstn;
	assign wv       = pmoc_pkg::pmoc_ctrl_t'(busReq.wdata);
	assign ctlWr    = busReq.wr && (busReq.addr == pmoc_pkg::ADDR_CTRL);
	assign busy     = (state == pmoc_pkg::ST_BUSY);
	assign reqKind  = decodeOp(wv.eraseSel, wv.opCode);
	// Start written while idle; a start written while busy is already set
	assign startReq = ctlWr && wv.start && !busy;
	assign badSeq   = startReq && (!wv.opWritePermit || reqKind == pmoc_pkg::MOP_BAD);
	assign launch   = startReq && !badSeq && reqKind != pmoc_pkg::MOP_NOP;
	assign nopDone  = startReq && !badSeq && reqKind == pmoc_pkg::MOP_NOP;
	// Dropping the permit mid-operation or a local reset ends it abnormally
	assign abortNow = busy && (memAbort || (ctlWr && !wv.opWritePermit) || !rstn);
	assign doneNow  = busy && memDone && !abortNow;

	// ==========================================================
	// Control bits, power-on reset only
	always_ff @(posedge clk) begin
		if (!porRstn) begin
			permitBit <= pmoc_pkg::CTRL_RESET.opWritePermit;
			eraseBit  <= pmoc_pkg::CTRL_RESET.eraseSel;
			opBits    <= pmoc_pkg::CTRL_RESET.opCode;
			errBit    <= pmoc_pkg::CTRL_RESET.sequenceErrorFlag;
		end else begin
			if (ctlWr) begin
				permitBit <= wv.opWritePermit;
			end
			// Selection frozen while an operation runs so memOp stays coherent
			if (ctlWr && !busy) begin
				eraseBit <= wv.eraseSel;
				opBits   <= wv.opCode;
			end
			// Normal finish also clears, so a software write during busy cannot leave it set
			if (badSeq || abortNow) begin
				errBit <= 1'b1;
			end else if (launch || nopDone || doneNow) begin
				errBit <= 1'b0;
			end else if (ctlWr) begin
				errBit <= wv.sequenceErrorFlag;
			end
		end
	end

	// Unimplemented bits tied low; one composed view for reads and checks
	assign ctl = '{start: startBit, opWritePermit: permitBit, sequenceErrorFlag: errBit,
		rsvHi: 6'h00, eraseSel: eraseBit, rsvLo: 2'h0, opCode: opBits};

	// ==========================================================
	// Sequencer
	always_ff @(posedge clk) begin
		if (anyRst) begin
			state    <= pmoc_pkg::ST_IDLE;
			startBit <= pmoc_pkg::CTRL_RESET.start;
			memGo    <= 1'b0;
			memOp    <= pmoc_pkg::MOP_NONE;
		end else begin
			case (state)
				pmoc_pkg::ST_IDLE: begin
					if (launch) begin
						state    <= pmoc_pkg::ST_BUSY;
						startBit <= 1'b1;
						memGo    <= 1'b1;
						memOp    <= reqKind;
					end
				end
				pmoc_pkg::ST_BUSY: begin
					if (doneNow || abortNow) begin
						state    <= pmoc_pkg::ST_IDLE;
						startBit <= 1'b0;
						memGo    <= 1'b0;
						memOp    <= pmoc_pkg::MOP_NONE;
					end
				end
				default: begin
					state    <= pmoc_pkg::ST_IDLE;
					startBit <= 1'b0;
					memGo     <= 1'b0;
					memOp     <= pmoc_pkg::MOP_NONE;
				end
			endcase
		end
	end

	// ==========================================================
	// Interrupt status and mask
	always_comb begin
		next_irqStat = irqStat;
		if (busReq.wr && busReq.addr == pmoc_pkg::ADDR_IRQ_ST) begin
			next_irqStat = irqStat & ~busReq.wdata[pmoc_pkg::IRQ_W-1:0];
		end
		// Set after clear so a same-cycle event is never lost
		if (doneNow || nopDone) begin
			next_irqStat[pmoc_pkg::IRQ_DONE] = 1'b1;
		end
		if (badSeq || abortNow) begin
			next_irqStat[pmoc_pkg::IRQ_ERR] = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (anyRst) begin
			irqStat <= pmoc_pkg::IRQ_RESET;
			irqMask <= pmoc_pkg::IRQ_RESET;
			irq     <= 1'b0;
		end else begin
			irqStat <= next_irqStat;
			if (busReq.wr && busReq.addr == pmoc_pkg::ADDR_IRQ_MSK) begin
				irqMask <= busReq.wdata[pmoc_pkg::IRQ_W-1:0];
			end
			irq <= |(next_irqStat & irqMask);
		end
	end

	// ==========================================================
	// Read port
	always_ff @(posedge clk) begin
		if (anyRst) begin
			rdata <= 16'h0000;
		end else if (busReq.rd) begin
			case (busReq.addr)
				pmoc_pkg::ADDR_CTRL:    rdata <= ctl;
				pmoc_pkg::ADDR_IRQ_ST:  rdata <= {14'h0000, irqStat};
				pmoc_pkg::ADDR_IRQ_MSK: rdata <= {14'h0000, irqMask};
				default:                rdata <= 16'h0000;
			endcase
		end else begin
			rdata <= 16'h0000;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (anyRst);

	a_go_needs_permit: assert property (launch |=> memGo && ctl.opWritePermit)
		else $error("launch without write permit or memGo");
	a_no_permit_no_go: assert property (startReq && !wv.opWritePermit |=> !memGo && ctl.sequenceErrorFlag)
		else $error("operation started with permit clear");
	a_abort_sets_err: assert property (abortNow && rstn |=> ctl.sequenceErrorFlag && !ctl.start)
		else $error("abnormal end did not flag error");
	a_bad_start_err: assert property (badSeq |=> ctl.sequenceErrorFlag && !memGo ##1 irqStat[pmoc_pkg::IRQ_ERR])
		else $error("improper start not flagged");
	a_normal_end_ok: assert property (doneNow |=> !ctl.sequenceErrorFlag)
		else $error("error set after normal finish");
	a_reserved_zero: assert property (busReq.rd |=> rdata[12:7] == 6'h00 && (
		$past(busReq.addr) != pmoc_pkg::ADDR_CTRL || rdata[5:4] == 2'h0))
		else $error("reserved bits read nonzero");
	a_erase_gen_code: assert property (launch && wv.eraseSel && wv.opCode == 4'hD
		|=> memOp == pmoc_pkg::MOP_ERASE_GEN)
		else $error("general segment erase not selected");
	a_word_prog_code: assert property (launch && !wv.eraseSel && wv.opCode == 4'h3
		|=> memOp == pmoc_pkg::MOP_PROG_WORD)
		else $error("word program not selected");
	a_reserved_refused: assert property (startReq && wv.opCode[3:1] == 3'h0 |=> !memGo)
		else $error("reserved code started an operation");
	a_start_tracks_busy: assert property (ctl.start == memGo)
		else $error("start bit disagrees with activity");
	a_nop_no_change: assert property (nopDone |=> !memGo ##1 irqStat[pmoc_pkg::IRQ_DONE])
		else $error("no-op start touched memory");

	// ==========================================================
	// Decode, sequencing, interrupt, read port and register write checks

	property p_page_erase;
		launch && wv.eraseSel && wv.opCode == pmoc_pkg::OPC_PAGE_ERASE |=> memOp == pmoc_pkg::MOP_ERASE_PAGE;
	endproperty
	a_page_erase_code: assert property (p_page_erase)
		else $error("page erase not selected");

	property p_erase_nop;
		startReq && wv.opWritePermit && wv.eraseSel
			&& (wv.opCode == pmoc_pkg::OPC_NOP_A || wv.opCode == pmoc_pkg::OPC_WORD_OR_NOP)
			|=> !memGo && !ctl.sequenceErrorFlag;
	endproperty
	a_erase_nop_code: assert property (p_erase_nop)
		else $error("erase no-op code started memory");

	property p_prog_nop;
		startReq && wv.opWritePermit && !wv.eraseSel
			&& (wv.opCode == pmoc_pkg::OPC_NOP_A || wv.opCode == pmoc_pkg::OPC_ERASE_GEN
			|| wv.opCode == pmoc_pkg::OPC_PAGE_ERASE)
			|=> !memGo && !ctl.sequenceErrorFlag;
	endproperty
	a_prog_nop_code: assert property (p_prog_nop)
		else $error("program no-op code started memory");

	property p_unlisted;
		startReq && reqKind == pmoc_pkg::MOP_BAD |=> !memGo && ctl.sequenceErrorFlag;
	endproperty
	a_unlisted_refused: assert property (p_unlisted)
		else $error("unlisted code not refused");

	property p_start_launch;
		launch |=> ctl.start && busy;
	endproperty
	a_start_on_launch: assert property (p_start_launch)
		else $error("start bit not set on launch");

	property p_start_clear;
		busy && (doneNow || abortNow) |=> !ctl.start && !memGo;
	endproperty
	a_start_clears: assert property (p_start_clear)
		else $error("start bit not cleared at finish");

	property p_idle_start;
		!busy |-> !ctl.start;
	endproperty
	a_idle_start_zero: assert property (p_idle_start)
		else $error("start reads one while idle");

	property p_idle_op;
		!memGo |-> memOp == pmoc_pkg::MOP_NONE;
	endproperty
	a_idle_op_none: assert property (p_idle_op)
		else $error("operation shown while idle");

	property p_permit_drop;
		busy && ctlWr && !wv.opWritePermit |=> !memGo && ctl.sequenceErrorFlag;
	endproperty
	a_permit_drop_err: assert property (p_permit_drop)
		else $error("permit drop did not end abnormally");

	property p_rsv_write;
		ctlWr |=> ctl.rsvHi == 6'h00 && ctl.rsvLo == 2'h0;
	endproperty
	a_rsv_write_ignored: assert property (p_rsv_write)
		else $error("unimplemented bits took a write");

	property p_sel_frozen;
		busy && !(doneNow || abortNow) |=> $stable(memOp) && $stable(ctl.opCode) && $stable(ctl.eraseSel);
	endproperty
	a_sel_frozen: assert property (p_sel_frozen)
		else $error("selection changed while busy");

	property p_busy_start;
		busy && ctlWr && wv.start && wv.opWritePermit && !memDone && !memAbort |=> busy && $stable(memOp);
	endproperty
	a_busy_start_ignored: assert property (p_busy_start)
		else $error("start while busy disturbed operation");

	property p_done_irq;
		doneNow |=> irqStat[pmoc_pkg::IRQ_DONE];
	endproperty
	a_done_status_set: assert property (p_done_irq)
		else $error("finish did not set done status");

	property p_err_irq;
		badSeq || abortNow |=> irqStat[pmoc_pkg::IRQ_ERR];
	endproperty
	a_err_status_set: assert property (p_err_irq)
		else $error("error did not set error status");

	property p_irq_masked;
		irqMask == 2'h0 |=> !irq;
	endproperty
	a_irq_masked_off: assert property (p_irq_masked)
		else $error("interrupt raised with mask clear");

	property p_rdata_idle;
		!busReq.rd |=> rdata == 16'h0000;
	endproperty
	a_rdata_idle_zero: assert property (p_rdata_idle)
		else $error("read data outside read cycle");

	property p_err_write;
		ctlWr && !busy && !wv.start |=> ctl.sequenceErrorFlag == $past(wv.sequenceErrorFlag);
	endproperty
	a_err_soft_write: assert property (p_err_write)
		else $error("error flag ignored software write");

	property p_permit_write;
		ctlWr |=> ctl.opWritePermit == $past(wv.opWritePermit);
	endproperty
	a_permit_write: assert property (p_permit_write)
		else $error("write permit ignored write");

	c_word_program: cover property (launch && !wv.eraseSel ##[1:1000] doneNow);
	c_page_erase:   cover property (launch && reqKind == pmoc_pkg::MOP_ERASE_PAGE ##[1:1000] doneNow);
	c_abort:        cover property (busy && memAbort);
	c_bad_seq:      cover property (badSeq);
	c_nop_start:    cover property (nopDone);

endmodule

// ==== testbench/program_memory_op_control_bench.sv ====
// Self-checking bench for the program memory operation control block
`timescale 1ns/100ps
`define CHK(got, exp) begin cmpCount++; if ((got) !== (exp)) begin mismatches++; $display("FAIL %0t: got %h want %h", $time, got, exp); end end
module program_memory_op_control_bench;
	// ==========================================================
	// Design connections
	logic                          clk = 1'b0;
	logic                          rstn;
	logic                          porRstn;
	pmoc_pkg::pmoc_bus_req_t       busReq;
	logic [pmoc_pkg::DATA_W-1:0]   rdata;
	logic                          memGo;
	pmoc_pkg::pmoc_mem_op_t        memOp;
	logic                          memDone;
	logic                          memAbort;
	logic                          irq;
	int                            mismatches = 0;
	int                            cmpCount = 0;
	logic [20:0]                   notes[$];
	logic                          rdSeen = 1'b0;

	always #2 clk = ~clk;

	pmoc_program_memory_op_control i_dut (
		.clk(clk), .rstn(rstn), .porRstn(porRstn), .busReq(busReq), .rdata(rdata),
		.memGo(memGo), .memOp(memOp), .memDone(memDone), .memAbort(memAbort), .irq(irq));

	// ==========================================================
	// Result watcher: every read also snapshots irq and the engine outputs
	always @(posedge clk) begin
		if (rdSeen) begin
			if (notes.size() == 0) begin
				mismatches++;
				$display("FAIL %0t: result without note", $time);
			end else `CHK({irq, memGo, memOp, rdata}, notes.pop_front())
		end
		rdSeen <= busReq.rd;
	end

	// ==========================================================
	// Bus and engine tasks; one idle cycle between strobes avoids double drives
	task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		busReq <= '{wr: w, rd: r, addr: a, wdata: d};
		@(posedge clk);
		busReq <= '0;
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] d, input logic i = 1'b0,
		input logic g = 1'b0, input logic [2:0] o = 3'h0);
		notes.push_back({i, g, o, d});
		bus(1'b0, 1'b1, a, 16'h0000);
	endtask

	task automatic pulse(input logic abort);
		@(posedge clk);
		if (abort) memAbort <= 1'b1;
		else memDone <= 1'b1;
		@(posedge clk);
		memAbort <= 1'b0;
		memDone <= 1'b0;
	endtask

	function automatic logic [15:0] ctl(input logic s, p, er, e, input logic [3:0] op);
		return {s, p, er, 6'h00, e, 2'h0, op};
	endfunction

	// Kind 2 runs the engine, 1 is a no-op, 0 is refused; low bits give the engine op
	function automatic logic [4:0] classify(input logic e, input logic [3:0] op);
		case ({e, op})
			5'h1D: return {2'h2, pmoc_pkg::MOP_ERASE_GEN};
			5'h12: return {2'h2, pmoc_pkg::MOP_ERASE_PAGE};
			5'h03: return {2'h2, pmoc_pkg::MOP_PROG_WORD};
			5'h1F, 5'h13, 5'h0F, 5'h0D, 5'h02: return 5'h08;
			default: return 5'h00;
		endcase
	endfunction

	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", cmpCount, mismatches);
		if (mismatches == 0 && cmpCount > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge clk);
		mismatches++;
		$display("FAIL %0t: run did not finish", $time);
		wrap_up();
	end

	// ==========================================================
	// Main sequence
	initial begin
		logic [4:0]  k;
		logic [15:0] r;
		logic        e;
		logic [3:0]  op;
		busReq = '0;
		memDone = 1'b0;
		memAbort = 1'b0;
		rstn = 1'b0;
		porRstn = 1'b0;
		void'($urandom(42785));
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		porRstn <= 1'b1;
		rd(pmoc_pkg::ADDR_CTRL, 16'h0000);
		rd(pmoc_pkg::ADDR_IRQ_ST, 16'h0000);
		rd(4'hC, 16'h0000);
		wr(pmoc_pkg::ADDR_CTRL, 16'h5FFA);
		rd(pmoc_pkg::ADDR_CTRL, ctl(0, 1, 0, 1, 4'hA));
		wr(pmoc_pkg::ADDR_IRQ_MSK, 16'h0003);
		rd(pmoc_pkg::ADDR_IRQ_MSK, 16'h0003);
		// Every mode and code, random junk in the unused bits
		for (int i = 0; i < 32; i++) begin
			e = i[4];
			op = i[3:0];
			k = classify(e, op);
			r = 16'($urandom);
			wr(pmoc_pkg::ADDR_IRQ_ST, 16'h0003);
			wr(pmoc_pkg::ADDR_CTRL, {3'b110, r[12:7], e, r[5:4], op});
			if (k[4:3] == 2'h2) begin
				rd(pmoc_pkg::ADDR_CTRL, ctl(1, 1, 0, e, op), 0, 1, k[2:0]);
				wr(pmoc_pkg::ADDR_CTRL, ctl(0, 1, 0, ~e, ~op));
				rd(pmoc_pkg::ADDR_CTRL, ctl(1, 1, 0, e, op), 0, 1, k[2:0]);
				pulse(1'b0);
				rd(pmoc_pkg::ADDR_CTRL, ctl(0, 1, 0, e, op), 1);
				rd(pmoc_pkg::ADDR_IRQ_ST, 16'h0001, 1);
			end else begin
				rd(pmoc_pkg::ADDR_CTRL, ctl(0, 1, ~k[3], e, op), 1);
				rd(pmoc_pkg::ADDR_IRQ_ST, {14'h0, ~k[3], k[3]}, 1);
			end
		end
		wr(pmoc_pkg::ADDR_IRQ_ST, 16'h0003);
		wr(pmoc_pkg::ADDR_CTRL, ctl(1, 0, 0, 0, 4'h3));
		rd(pmoc_pkg::ADDR_CTRL, ctl(0, 0, 1, 0, 4'h3), 1);
		wr(pmoc_pkg::ADDR_IRQ_MSK, 16'h0001);
		rd(pmoc_pkg::ADDR_IRQ_ST, 16'h0002, 0);
		// Abnormal end by abort
		wr(pmoc_pkg::ADDR_IRQ_MSK, 16'h0003);
		wr(pmoc_pkg::ADDR_IRQ_ST, 16'h0003);
		wr(pmoc_pkg::ADDR_CTRL, ctl(1, 1, 0, 0, 4'h3));
		pulse(1'b1);
		rd(pmoc_pkg::ADDR_CTRL, ctl(0, 1, 1, 0, 4'h3), 1);
		// Local reset mid-operation sets error, clears start, keeps the other control bits
		wr(pmoc_pkg::ADDR_CTRL, ctl(1, 1, 0, 1, 4'h2));
		@(posedge clk);
		rstn <= 1'b0;
		@(posedge clk);
		rstn <= 1'b1;
		rd(pmoc_pkg::ADDR_CTRL, ctl(0, 1, 1, 1, 4'h2));
		@(posedge clk);
		porRstn <= 1'b0;
		@(posedge clk);
		porRstn <= 1'b1;
		rd(pmoc_pkg::ADDR_CTRL, 16'h0000);
		repeat (4) @(posedge clk);
		wrap_up();
	end
endmodule
